// ---- core/iec_pkg.sv ----
package iec_pkg;

    // Payload carried by one channel in one bunch crossing, and its check field
    localparam int          CH_DATA_W = 32;
    localparam int          CRC_W     = 10;
    localparam int          LINK_W    = CH_DATA_W + CRC_W;

    // Check polynomial (x^10 + x^9 + x^5 + x^4 + x + 1), seed of the shift register
    localparam logic [9:0]  CRC_POLY  = 10'h233;
    localparam logic [9:0]  CRC_INIT  = 10'h000;

    // Replay memory depth and its address width
    localparam int          REPLAY_DEPTH = 256;
    localparam int          REPLAY_AW    = $clog2(REPLAY_DEPTH);

    // Default width of the error-cycle counter
    localparam int          ERR_CNT_W = 16;

    // Memory bank codes for the load port
    localparam logic        BANK_INPUT  = 1'b0;
    localparam logic        BANK_OUTPUT = 1'b1;

    // One deserialized link word: payload in the upper bits, check field below
    typedef struct packed {
        logic [CH_DATA_W-1:0] data;
        logic [CRC_W-1:0]     crc;
    } iec_link_word_t;

    // Error summary inserted beside the readout data of a bunch crossing
    typedef struct packed {
        logic                 err_flag;
        logic [ERR_CNT_W-1:0] err_count;
    } iec_ro_status_t;

endpackage

// ---- core/iec_input_check.sv ----
`timescale 1ns/10ps
// Operation
// [R1] Check CRC right after serial-to-parallel conversion
// [R2] Zero errored words on real-time path
// [R3] Readout path gets errored data unchanged
// [R4] Per-cycle flag is OR of channel checks
// [R5] Counter increments once per errored cycle
// [R6] Per-channel sticky bit holds until clear
// [R7] Global error is OR of sticky bits
// [R8] Flag, counter, sticky and global readable
// [R9] One clear command resets all error state
// [R10] Flag and counter travel with readout data
// [R11] No dedicated external error output exists
// [R12] Replay injects memory data, ignores live inputs
// [R13] Optional replay memories drive real-time output
// [R14] Replay is global; output memories optional
// [R15] Replay memories hold 256 software-loaded words
// [R16] Each payload carries a 10-bit CRC
// [R17] Readout selects errored channels unless all-enabled
// [R18] Clear first, then new error; counter saturates
module iec_input_check
    import iec_pkg::*;
#(
    parameter int N_CH    = 4,            // Number of input channels
    parameter int DEPTH   = REPLAY_DEPTH, // Replay memory depth
    parameter int CNT_W   = ERR_CNT_W     // Error-cycle counter width
) (
    input  wire logic                          MCLK,
    input  wire logic                          RESET_N,
    input  wire logic                          LINK_CLK,
    input  wire logic [N_CH*LINK_W-1:0]        LINK_DATA,
    input  wire logic [N_CH*CH_DATA_W-1:0]     PROC_RESULT,
    input  wire logic                          ERR_CLEAR,
    input  wire logic                          REPLAY_EN,
    input  wire logic                          REPLAY_OUT_EN,
    input  wire logic                          READOUT_ALL,
    input  wire logic                          MEM_WR_EN,
    input  wire logic                          MEM_WR_BANK,
    input  wire logic [$clog2(N_CH)-1:0]       MEM_WR_CH,
    input  wire logic [$clog2(DEPTH)-1:0]      MEM_WR_ADDR,
    input  wire logic [CH_DATA_W-1:0]          MEM_WR_DATA,
    output logic                               BC_VALID,
    output logic [N_CH*CH_DATA_W-1:0]          FE_DATA,
    output logic [N_CH*CH_DATA_W-1:0]          RT_OUT,
    output logic [N_CH*CH_DATA_W-1:0]          RO_DATA,
    output logic [N_CH-1:0]                    RO_SEL,
    output logic                               RO_ERR_FLAG,
    output logic [CNT_W-1:0]                   RO_ERR_COUNT,
    output logic                               ERR_FLAG,
    output logic [CNT_W-1:0]                   ERR_COUNT,
    output logic [N_CH-1:0]                    ERR_LATCH,
    output logic                               ERR_ANY
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [CNT_W-1:0] CNT_MAX  = '1;
    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [AW-1:0]    PTR_LAST = AW'(DEPTH - 1);

    // Shift-register check over the payload, most significant bit first
    function automatic logic [CRC_W-1:0] crc_of(input logic [CH_DATA_W-1:0] d);
        logic [CRC_W-1:0] c;
        logic             fb;
        c  = CRC_INIT;
        fb = 1'b0;
        for (int i = CH_DATA_W - 1; i >= 0; i--) begin
            fb = c[CRC_W-1] ^ d[i];
            c  = {c[CRC_W-2:0], 1'b0};
            if (fb) begin
                c = c ^ CRC_POLY;
            end
        end
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Link sampling
    ////////////////////////////////////////////////////////////////////////////////

    logic                      lclk_s1_reg;   // First stage, read only by second
    logic                      lclk_s2_reg;   // Synchronised link clock
    logic                      lclk_prev_reg; // Previous value for edge finding
    logic [N_CH*LINK_W-1:0]    ldat_s1_reg;   // First stage of link data
    logic [N_CH*LINK_W-1:0]    ldat_s2_reg;   // Synchronised link data
    logic                      bc_stb;        // One pulse per bunch crossing word

    // Two flip-flops on every link pin before any logic sees it
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            lclk_s1_reg   <= 1'b0;
            lclk_s2_reg   <= 1'b0;
            lclk_prev_reg <= 1'b0;
            ldat_s1_reg   <= '0;
            ldat_s2_reg   <= '0;
        end else begin
            lclk_s1_reg   <= LINK_CLK;
            lclk_s2_reg   <= lclk_s1_reg;
            lclk_prev_reg <= lclk_s2_reg;
            ldat_s1_reg   <= LINK_DATA;
            ldat_s2_reg   <= ldat_s1_reg;
        end
    end

    // Data is stable around the rising link edge, so take it there
    assign bc_stb = lclk_s2_reg & ~lclk_prev_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Replay memories
    ////////////////////////////////////////////////////////////////////////////////

    logic [CH_DATA_W-1:0] in_mem  [N_CH][DEPTH]; // Input replay words
    logic [CH_DATA_W-1:0] out_mem [N_CH][DEPTH]; // Output replay words
    logic [AW-1:0]        ptr_reg;               // Scrolling read address

    // Software load port; no reset so the arrays map onto block memory
    always_ff @(posedge MCLK) begin
        if (MEM_WR_EN && MEM_WR_BANK == BANK_INPUT) begin
            in_mem[MEM_WR_CH][MEM_WR_ADDR] <= MEM_WR_DATA;  // see [R15]
        end
        if (MEM_WR_EN && MEM_WR_BANK == BANK_OUTPUT) begin
            out_mem[MEM_WR_CH][MEM_WR_ADDR] <= MEM_WR_DATA; // see [R15]
        end
    end

    // Address scrolls once per crossing and wraps after the last word
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ptr_reg <= '0;
        end else if (!REPLAY_EN) begin
            ptr_reg <= '0;                    // Restart from word 0 on each entry
        end else if (bc_stb) begin
            ptr_reg <= (ptr_reg == PTR_LAST) ? '0 : ptr_reg + AW'(1); // see [R15]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-channel check
    ////////////////////////////////////////////////////////////////////////////////

    logic [N_CH*CH_DATA_W-1:0] raw_data;   // Payload as received (or replayed)
    logic [N_CH*CH_DATA_W-1:0] clean_data; // Payload with errored words zeroed
    logic [N_CH*CH_DATA_W-1:0] out_word;   // Output replay words at pointer
    logic [N_CH-1:0]           ch_err;     // Check result per channel

    for (genvar g = 0; g < N_CH; g++) begin : g_ch
        iec_link_word_t w;
        logic [CH_DATA_W-1:0] pb;
        assign w  = iec_link_word_t'(ldat_s2_reg[g*LINK_W +: LINK_W]);
        assign pb = in_mem[g][ptr_reg];
        // Live payload is checked straight after deserialisation
        assign ch_err[g] = ~REPLAY_EN & (crc_of(w.data) != w.crc);  // see [R1] see [R16]
        // Replay replaces live words for every channel together
        assign raw_data[g*CH_DATA_W +: CH_DATA_W] = REPLAY_EN ? pb : w.data; // see [R12] [R14]
        assign clean_data[g*CH_DATA_W +: CH_DATA_W] =
            ch_err[g] ? '0 : raw_data[g*CH_DATA_W +: CH_DATA_W];     // see [R2]
        assign out_word[g*CH_DATA_W +: CH_DATA_W] = out_mem[g][ptr_reg];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Data paths
    ////////////////////////////////////////////////////////////////////////////////

    logic bc_err; // Any channel failed this crossing
    assign bc_err = |ch_err;

    // Real-time, readout and output paths all advance on the crossing strobe
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            BC_VALID <= 1'b0;
            FE_DATA  <= '0;
            RT_OUT   <= '0;
            RO_DATA  <= '0;
            RO_SEL   <= '0;
        end else begin
            BC_VALID <= bc_stb;
            if (bc_stb) begin
                FE_DATA <= clean_data;                             // see [R2]
                RO_DATA <= raw_data;                               // see [R3]
                RO_SEL  <= ch_err | {N_CH{READOUT_ALL}};           // see [R17]
                // Output replay may disagree with what readout carries
                RT_OUT  <= (REPLAY_EN && REPLAY_OUT_EN) ? out_word : PROC_RESULT; // see [R13]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Error status
    ////////////////////////////////////////////////////////////////////////////////

    logic [CNT_W-1:0] cnt_base; // Counter after any clear of this cycle
    logic [N_CH-1:0]  latch_base;
    assign cnt_base   = ERR_CLEAR ? CNT_ZERO : ERR_COUNT;     // see [R9] [R18]
    assign latch_base = ERR_CLEAR ? '0 : ERR_LATCH;           // see [R9] [R18]

    // Per-cycle flag follows the current crossing; clear wipes a stale one
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ERR_FLAG <= 1'b0;
        end else if (bc_stb) begin
            ERR_FLAG <= bc_err;                                // see [R4] [R8]
        end else if (ERR_CLEAR) begin
            ERR_FLAG <= 1'b0;                                  // see [R9]
        end
    end

    // Counter saturates so a long outage never looks like a clean run
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ERR_COUNT <= '0;
        end else if (bc_stb && bc_err) begin
            ERR_COUNT <= (cnt_base == CNT_MAX) ? CNT_MAX : cnt_base + CNT_ONE; // see [R5] [R18]
        end else begin
            ERR_COUNT <= cnt_base;                             // see [R9] [R8]
        end
    end

    // Sticky bits: the new error is recorded after the clear, so it wins
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ERR_LATCH <= '0;
            ERR_ANY   <= 1'b0;
        end else begin
            ERR_LATCH <= latch_base | (bc_stb ? ch_err : '0);  // see [R6] [R18] [R8]
            ERR_ANY   <= |(latch_base | (bc_stb ? ch_err : '0)); // see [R7] [R8]
        end
    end

    // Summary inserted into the readout of the same crossing
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            RO_ERR_FLAG  <= 1'b0;
            RO_ERR_COUNT <= '0;
        end else if (bc_stb) begin
            RO_ERR_FLAG  <= bc_err;                            // see [R10]
            RO_ERR_COUNT <= bc_err ? ((cnt_base == CNT_MAX) ? CNT_MAX : cnt_base + CNT_ONE)
                                   : cnt_base;                 // see [R10]
        end
    end

    // Status is only visible on the status ports and in readout   see [R11]

endmodule // iec_input_check

// ---- verif/iec_input_check_props.sv ----
`timescale 1ns/10ps
// Error bookkeeping, judged from the top ports only
module iec_input_check_props
    import iec_pkg::*;
#(
    parameter int N_CH  = 4,
    parameter int CNT_W = 16
) (
    input wire logic                      MCLK,
    input wire logic                      RESET_N,
    input wire logic                      LINK_CLK,
    input wire logic                      ERR_CLEAR,
    input wire logic                      READOUT_ALL,
    input wire logic                      BC_VALID,
    input wire logic [N_CH*CH_DATA_W-1:0] FE_DATA,
    input wire logic [N_CH-1:0]           RO_SEL,
    input wire logic                      RO_ERR_FLAG,
    input wire logic [CNT_W-1:0]          RO_ERR_COUNT,
    input wire logic                      ERR_FLAG,
    input wire logic [CNT_W-1:0]          ERR_COUNT,
    input wire logic [N_CH-1:0]           ERR_LATCH,
    input wire logic                      ERR_ANY
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESET_N);
    logic [N_CH-1:0] fe_zero;  // Channels whose real-time word is zero
    // A zero payload is legal, so this only shows that errored words were forced
    always_comb begin
        for (int g = 0; g < N_CH; g++) fe_zero[g] = ~|FE_DATA[g*CH_DATA_W+:CH_DATA_W];
    end
    //////////////////////////////////////////////////////////////////////
    sequence s_rise; $rose(LINK_CLK); endsequence
    sequence s_strobe; BC_VALID ##1 !BC_VALID; endsequence
    property p_latency; s_rise |-> ##[2:6] s_strobe; endproperty
    a_latency: assert property (p_latency) else $error("no crossing strobe");
    property p_any; ERR_ANY == |ERR_LATCH; endproperty
    a_any: assert property (p_any) else $error("global bit wrong");
    property p_clear; ERR_CLEAR |=> BC_VALID ||
        (ERR_COUNT == '0 && ERR_LATCH == '0 && !ERR_FLAG); endproperty
    a_clear: assert property (p_clear) else $error("clear missed");
    property p_count; BC_VALID && ERR_FLAG && !$past(ERR_CLEAR) && !(&$past(ERR_COUNT))
        |-> ERR_COUNT == $past(ERR_COUNT) + 1'b1; endproperty
    a_count: assert property (p_count) else $error("count step wrong");
    property p_first; BC_VALID && ERR_FLAG && $past(ERR_CLEAR) |-> ERR_COUNT == CNT_W'(1);
    endproperty
    a_first: assert property (p_first) else $error("clear beat error");
    property p_sat; &$past(ERR_COUNT) && !$past(ERR_CLEAR) |-> &ERR_COUNT; endproperty
    a_sat: assert property (p_sat) else $error("count wrapped");
    property p_ro; BC_VALID |-> RO_ERR_FLAG == ERR_FLAG && RO_ERR_COUNT == ERR_COUNT;
    endproperty
    a_ro: assert property (p_ro) else $error("readout status wrong");
    property p_zero; BC_VALID && !$past(READOUT_ALL) |-> (RO_SEL & ~fe_zero) == '0 &&
        ERR_FLAG == |RO_SEL && (RO_SEL & ~ERR_LATCH) == '0; endproperty
    a_zero: assert property (p_zero) else $error("errored word kept");
    property p_sticky; |($past(ERR_LATCH) & ~ERR_LATCH) |-> $past(ERR_CLEAR); endproperty
    a_sticky: assert property (p_sticky) else $error("latch fell");
endmodule // iec_input_check_props

// ---- verif/iec_link_src.sv ----
`timescale 1ns/10ps
// Upstream link: one word per channel per crossing, check field optionally spoiled
module iec_link_src
    import iec_pkg::*;
#(
    parameter int N_CH = 4
) (
    input wire logic              clk,
    output logic                  link_clk,
    output logic [N_CH*LINK_W-1:0] link_data
);
    // Serial check, payload MSB first, no final inversion
    function automatic logic [CRC_W-1:0] crc10(input logic [CH_DATA_W-1:0] d);
        logic [CRC_W-1:0] c;
        c = CRC_INIT;
        for (int i = CH_DATA_W-1; i >= 0; i--) begin
            c = {c[CRC_W-2:0], 1'b0} ^ ((c[CRC_W-1] ^ d[i]) ? CRC_POLY : '0);
        end
        return c;
    endfunction
    // Declaration values hold the link idle through reset without a second writer
    logic                   clk_q  = 1'b0;
    logic [N_CH*LINK_W-1:0] word_q = '0;
    assign link_clk  = clk_q;
    assign link_data = word_q;
    // Word settles two cycles before the rise; 4 cycles high and 4 low give 160 ns
    task automatic send(input logic [N_CH*CH_DATA_W-1:0] d, input logic [N_CH-1:0] bad);
        logic [N_CH*LINK_W-1:0] w;
        for (int g = 0; g < N_CH; g++) begin
            w[g*LINK_W+:LINK_W] = {d[g*CH_DATA_W+:CH_DATA_W],
                crc10(d[g*CH_DATA_W+:CH_DATA_W]) ^ {9'h0, bad[g]}};
        end
        word_q = w;
        repeat (2) @(negedge clk);
        clk_q = 1'b1;
        repeat (4) @(negedge clk);
        clk_q = 1'b0;
        // Spoil the word once taken, so a stale copy never looks valid
        word_q = ~word_q;
        repeat (2) @(negedge clk);
    endtask
endmodule // iec_link_src

// ---- verif/tb_iec_input_check.sv ----
`timescale 1ns/10ps
module tb_iec_input_check
    import iec_pkg::*;
();
    localparam int N  = 4;
    localparam int CW = 3;  // Short counter so saturation comes quickly
    localparam logic [N*CH_DATA_W-1:0] D = 128'h0000_00f1_1234_5678_dead_beef_8000_0001;
    logic                   mclk, reset_n, link_clk, err_clear, rp_en, rp_out, ro_all;
    logic                   wr_en, wr_bank, bc_valid, err_flag, ro_flag, err_any, s_flag;
    logic [1:0]             wr_ch;
    logic [REPLAY_AW-1:0]   wr_addr;
    logic [CH_DATA_W-1:0]   wr_data;
    logic [N*LINK_W-1:0]    link_data;
    logic [N*CH_DATA_W-1:0] proc, fe, rt, ro, s_fe, s_rt, s_ro;
    logic [N-1:0]           ro_sel, latch, s_sel;
    logic [CW-1:0]          cnt, ro_cnt, s_cnt;
    int                     error_cnt = 0;
    int                     cmp_count = 0;
    int                     bc_seen   = 0;  // Crossing strobes seen so far
    iec_input_check #(.N_CH(N), .CNT_W(CW)) i_iec_input_check (.MCLK(mclk), .RESET_N(reset_n),
        .LINK_CLK(link_clk), .LINK_DATA(link_data), .PROC_RESULT(proc), .ERR_CLEAR(err_clear),
        .REPLAY_EN(rp_en), .REPLAY_OUT_EN(rp_out), .READOUT_ALL(ro_all), .MEM_WR_EN(wr_en),
        .MEM_WR_BANK(wr_bank), .MEM_WR_CH(wr_ch), .MEM_WR_ADDR(wr_addr), .MEM_WR_DATA(wr_data),
        .BC_VALID(bc_valid), .FE_DATA(fe), .RT_OUT(rt), .RO_DATA(ro), .RO_SEL(ro_sel),
        .RO_ERR_FLAG(ro_flag), .RO_ERR_COUNT(ro_cnt), .ERR_FLAG(err_flag), .ERR_COUNT(cnt),
        .ERR_LATCH(latch), .ERR_ANY(err_any));
    iec_link_src #(.N_CH(N)) i_iec_link_src (.clk(mclk), .link_clk(link_clk),
        .link_data(link_data));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // Outputs stand until the next crossing, but the strobe lasts one cycle: grab them there
    always @(posedge mclk) begin
        if (bc_valid === 1'b1) begin
            {s_fe, s_rt, s_ro, s_sel, s_flag, s_cnt} <= {fe, rt, ro, ro_sel, ro_flag, ro_cnt};
            bc_seen <= bc_seen + 1;
        end
    end
    //////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("compares %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input logic ok, input string what);
        cmp_count++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("ERROR %0t: %s", $time, what);
        end
    endtask
    function automatic logic [N*CH_DATA_W-1:0] zap(input logic [N*CH_DATA_W-1:0] d,
        input logic [N-1:0] m);
        for (int g = 0; g < N; g++) if (m[g]) d[g*CH_DATA_W+:CH_DATA_W] = '0;
        return d;
    endfunction
    // Replay word pattern: bank, channel and address all visible in the word
    function automatic logic [CH_DATA_W-1:0] mw(input int b, input int g, input int a);
        return {8'(b + 8'ha0), 8'(g), 8'(a), 8'h5c};
    endfunction
    // One crossing; the strobe is bounded by the length of the link period
    task automatic xing(input logic [N*CH_DATA_W-1:0] d, input logic [N-1:0] bad);
        int n0;
        n0   = bc_seen;
        proc = ~d;
        i_iec_link_src.send(d, bad);
        check(bc_seen == n0 + 1, "not one strobe");
        if (bc_seen != n0 + 1) begin
            print_verdict();
        end
    endtask
    task automatic t_errors();
        xing(D, 4'h0);
        check(s_fe === D && s_rt === ~D, "clean data");
        check(s_sel === 4'h0 && s_flag === 1'b0, "clean flag");
        xing(D, 4'ha);
        check(s_fe === zap(D, 4'ha), "not zeroed");
        check(s_ro === D && s_sel === 4'ha, "readout copy");
        check(err_flag === 1'b1 && s_flag === 1'b1 && s_cnt === 3'h1, "flag");
        xing(D, 4'hf);
        check(cnt === 3'h2 && latch === 4'hf && err_any === 1'b1, "count");
        ro_all = 1'b1;
        xing(D, 4'h0);
        check(s_sel === 4'hf && err_flag === 1'b0 && latch === 4'hf, "sticky");
        ro_all = 1'b0;
        repeat (6) xing(D, 4'h1);
        check(cnt === 3'h7, "saturation");
        $display("errors test done");
    endtask
    task automatic t_clear();
        err_clear = 1'b1;
        @(negedge mclk);
        err_clear = 1'b0;
        check(cnt === 3'h0 && latch === 4'h0 && err_flag === 1'b0, "clr");
        check(err_any === 1'b0, "clr global");
        // Let an edge pass so the two clears are separate commands
        @(negedge mclk);
        err_clear = 1'b1;
        xing(D, 4'h4);
        check(s_cnt === 3'h1 && s_flag === 1'b1, "error lost to clear");
        err_clear = 1'b0;
        check(cnt === 3'h0 && latch === 4'h0, "level clear");
        $display("clear test done");
    endtask
    task automatic t_replay();
        // k: bit 0 bank, bit 1 address, upper bits channel
        for (int k = 0; k < 4*N; k++) begin
            wr_en = 1'b1;
            wr_bank = k[0];
            wr_addr = REPLAY_AW'(k[1]);
            wr_ch = 2'(k >> 2);
            wr_data = mw(k[0], k >> 2, k[1]);
            @(negedge mclk);
        end
        wr_en = 1'b0;
        rp_en = 1'b1;
        rp_out = 1'b1;
        for (int a = 0; a < 2; a++) begin
            xing(D, 4'hf);
            for (int g = 0; g < N; g++) begin
                check(s_fe[g*CH_DATA_W+:CH_DATA_W] === mw(0, g, a), "play in");
                check(s_rt[g*CH_DATA_W+:CH_DATA_W] === mw(1, g, a), "play out");
            end
        end
        check(cnt === 3'h0 && s_flag === 1'b0, "live link used");
        // One cycle out of replay rewinds the address; output memories now off
        rp_en = 1'b0;
        @(negedge mclk);
        rp_en = 1'b1;
        rp_out = 1'b0;
        xing(D, 4'h0);
        for (int g = 0; g < N; g++) begin
            check(s_ro[g*CH_DATA_W+:CH_DATA_W] === mw(0, g, 0), "rewind");
        end
        check(s_rt === ~D, "replay out off");
        rp_en = 1'b0;
        rp_out = 1'b0;
        $display("replay test done");
    endtask
    initial begin
        {reset_n, err_clear, rp_en, rp_out, ro_all, wr_en, wr_bank} = '0;
        {wr_ch, wr_addr, wr_data, proc} = '0;
        // Count rising edges: the clock's first fall comes from an unknown level
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        reset_n = 1'b1;
        repeat (4) @(negedge mclk);
        t_errors();
        t_clear();
        t_replay();
        print_verdict();
    end
endmodule // tb_iec_input_check
bind iec_input_check iec_input_check_props #(.N_CH(N_CH), .CNT_W(CNT_W)) i_props (.MCLK(MCLK),
    .RESET_N(RESET_N), .LINK_CLK(LINK_CLK), .ERR_CLEAR(ERR_CLEAR), .READOUT_ALL(READOUT_ALL),
    .BC_VALID(BC_VALID), .FE_DATA(FE_DATA), .RO_SEL(RO_SEL), .RO_ERR_FLAG(RO_ERR_FLAG),
    .RO_ERR_COUNT(RO_ERR_COUNT), .ERR_FLAG(ERR_FLAG), .ERR_COUNT(ERR_COUNT),
    .ERR_LATCH(ERR_LATCH), .ERR_ANY(ERR_ANY));
